// ==== rtl/gsr_cmd_top.sv ====
// What this block does
// - Fetch waits 1 ms, then returns CO2, temperature, humidity words with CRC.
// - Fetching a sample removes it from the result buffer.
// - Fetch with an empty buffer is answered with NACK.
// - Master may NACK then STOP after any byte; device releases the bus.
// - Temperature word: degC = -45 + 175 * word / (2^16 - 1).
// - Humidity word: percent = 100 * word / (2^16 - 1).
// - Stop command returns to idle; commands ignored for 500 ms after.
// - Offset is read or written only while idle; pressure can be written in either mode.
// - Written settings live in working storage until persisted.
// - Offset write: command, word, CRC; word = degC*2^16/175; 1 ms.
// - Temperature offset is 4 degC after power-up.
// - Offset read returns one word with CRC after 1 ms.
// - Offset affects temperature and humidity only, never CO2.
// - Master-supplied pressure compensates the CO2 result.
// - Words go MSB first, each followed by an 8-bit CRC.
// - Slave address 0x62; commands are 16-bit codes.
`timescale 1ns/1ps
`default_nettype none
module gsr_fifo #(
    parameter int unsigned W = 16,
    parameter int unsigned D = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic [$clog2(D):0] count_o
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q;
    logic push, pop;

    assign in_ready_o = cnt_q != (AW+1)'(D);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem_q[rp_q];
    assign count_o = cnt_q;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + AW'(1);
            end
            if (pop) begin
                rp_q <= rp_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // gsr_fifo

module gsr_cmd_top import gsr_pkg::*; #(
    parameter int unsigned EXEC_CYCLES = EXEC_CYC,
    parameter int unsigned STOP_CYCLES = STOP_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Two-wire serial bus, open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Measurement words from the sensing core
    input wire logic meas_valid_i,
    input wire logic [15:0] meas_data_i,
    output logic meas_ready_o,
    // Mode and settings towards the sensing core
    output logic periodic_o,
    output logic [15:0] temp_offset_o,
    output logic [15:0] pressure_o
);
    logic [1:0] scl_sy_q, sda_sy_q;
    logic scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    gsr_bus_st_type st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic oe_q, rd_q, mack_q, wdone_q, rdack_q;
    logic [2:0] bidx_q;
    logic [39:0] wbuf_q;
    logic [1:0] wsel_q, bsel_q, wsel_n, bsel_n;
    logic [7:0] tx_byte;
    logic per_q, rdok_q;
    logic [TMR_W-1:0] tmr_q;
    logic [1:0] pop_q, pidx_q;
    logic [15:0] ofs_q, prs_q;
    logic [15:0] res_q [WORDS_MEAS];
    logic ff_valid, ff_ready;
    logic [15:0] ff_data;
    logic [4:0] ff_cnt;
    logic busy, addr_ack, cmd_ev, par_ev, crc_ok;
    logic [15:0] cmd_w, pcmd_w, pword_w;

    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Samples queue here so a slow master never loses one
    gsr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_res_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(meas_valid_i),
        .in_data_i(meas_data_i),
        .in_ready_o(meas_ready_o),
        .out_valid_o(ff_valid),
        .out_data_o(ff_data),
        .out_ready_i(ff_ready),
        .count_o(ff_cnt)
    );

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_sy_q <= 2'h3;
            sda_sy_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_sy_q <= {scl_sy_q[0], scl_i};
            sda_sy_q <= {sda_sy_q[0], sda_i};
            scl_p_q <= scl_sy_q[1];
            sda_p_q <= sda_sy_q[1];
        end
    end

    assign scl_rise = scl_sy_q[1] && !scl_p_q;
    assign scl_fall = !scl_sy_q[1] && scl_p_q;
    assign bus_start = scl_sy_q[1] && scl_p_q && sda_p_q && !sda_sy_q[1];
    assign bus_stop = scl_sy_q[1] && scl_p_q && !sda_p_q && sda_sy_q[1];

    assign busy = tmr_q != '0;
    assign addr_ack = sh_q[7:1] == DEV_ADDR && !busy &&
        (!sh_q[0] || (rdok_q && pop_q == 2'h0));
    assign cmd_ev = wdone_q && bidx_q == 3'(BYTES_CMD);
    assign par_ev = wdone_q && bidx_q == 3'(BYTES_PAR);
    assign cmd_w = wbuf_q[15:0];
    assign pcmd_w = wbuf_q[39:24];
    assign pword_w = wbuf_q[23:8];
    assign crc_ok = crc8(pword_w) == wbuf_q[7:0];

    // Read stream: high byte, low byte, checksum per word
    always_comb begin
        tx_byte = IDLE_BYTE;
        if (wsel_q < 2'(WORDS_MEAS)) begin
            case (bsel_q)
                2'h0: tx_byte = res_q[wsel_q][15:8];
                2'h1: tx_byte = res_q[wsel_q][7:0];
                default: tx_byte = crc8(res_q[wsel_q]);
            endcase
        end
    end
    assign bsel_n = bsel_q == 2'h2 ? 2'h0 : bsel_q + 2'h1;
    assign wsel_n = (bsel_q == 2'h2 && wsel_q != 2'h3) ? wsel_q + 2'h1 : wsel_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            oe_q <= 1'b0;
            rd_q <= 1'b0;
            mack_q <= 1'b0;
            wdone_q <= 1'b0;
            rdack_q <= 1'b0;
            bidx_q <= 3'h0;
            wbuf_q <= 40'h0;
            wsel_q <= 2'h0;
            bsel_q <= 2'h0;
        end else begin
            wdone_q <= 1'b0;
            rdack_q <= 1'b0;
            if (bus_start) begin
                st_q <= ST_ADDR;
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
                bidx_q <= 3'h0;
            end else if (bus_stop) begin
                st_q <= ST_IDLE;
                oe_q <= 1'b0;
            end else begin
                case (st_q)
                    ST_ADDR, ST_WRB: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda_sy_q[1]};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == 4'h8) begin
                            cnt_q <= 4'h0;
                            if (st_q == ST_ADDR) begin
                                st_q <= ST_AACK;
                                oe_q <= addr_ack;
                                rd_q <= sh_q[0];
                                wsel_q <= 2'h0;
                                bsel_q <= 2'h0;
                            end else begin
                                st_q <= ST_WACK;
                                oe_q <= 1'b1;
                                wbuf_q <= {wbuf_q[31:0], sh_q};
                                if (bidx_q != 3'h7) begin
                                    bidx_q <= bidx_q + 3'h1;
                                end
                                wdone_q <= 1'b1;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            if (!oe_q) begin
                                st_q <= ST_IDLE;
                            end else if (rd_q) begin
                                st_q <= ST_RDB;
                                oe_q <= !tx_byte[7];
                                sh_q <= {tx_byte[6:0], 1'b0};
                                cnt_q <= 4'h1;
                                wsel_q <= wsel_n;
                                bsel_q <= bsel_n;
                                rdack_q <= 1'b1;
                            end else begin
                                st_q <= ST_WRB;
                                oe_q <= 1'b0;
                            end
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            st_q <= ST_WRB;
                            oe_q <= 1'b0;
                        end
                    end
                    ST_RDB: begin
                        if (scl_fall) begin
                            if (cnt_q == 4'h8) begin
                                st_q <= ST_RACK;
                                oe_q <= 1'b0;
                                cnt_q <= 4'h0;
                            end else begin
                                oe_q <= !sh_q[7];
                                sh_q <= {sh_q[6:0], 1'b0};
                                cnt_q <= cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            mack_q <= !sda_sy_q[1];
                        end else if (scl_fall) begin
                            if (mack_q) begin
                                st_q <= ST_RDB;
                                oe_q <= !tx_byte[7];
                                sh_q <= {tx_byte[6:0], 1'b0};
                                cnt_q <= 4'h1;
                                wsel_q <= wsel_n;
                                bsel_q <= bsel_n;
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    assign ff_ready = pop_q != 2'h0;

    // Command execution; settings are working copies only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            per_q <= 1'b0;
            tmr_q <= '0;
            rdok_q <= 1'b0;
            pop_q <= 2'h0;
            pidx_q <= 2'h0;
            ofs_q <= OFS_RST;
            prs_q <= PRS_RST;
            for (int i = 0; i < WORDS_MEAS; i++) begin
                res_q[i] <= 16'h0000;
            end
        end else begin
            if (busy) begin
                tmr_q <= tmr_q - TMR_W'(1);
            end
            if (rdack_q) begin
                rdok_q <= 1'b0;
            end
            if (ff_ready && ff_valid) begin
                res_q[pidx_q] <= ff_data;
                pidx_q <= pidx_q + 2'h1;
                pop_q <= pop_q - 2'h1;
            end
            if (cmd_ev) begin
                rdok_q <= 1'b0;
                case (cmd_w)
                    CMD_FETCH: begin
                        tmr_q <= TMR_W'(EXEC_CYCLES);
                        if (ff_cnt >= 5'(WORDS_MEAS)) begin
                            pop_q <= 2'(WORDS_MEAS);
                            pidx_q <= 2'h0;
                            rdok_q <= 1'b1;
                        end
                    end
                    CMD_STOP: begin
                        per_q <= 1'b0;
                        tmr_q <= TMR_W'(STOP_CYCLES);
                    end
                    CMD_START: per_q <= 1'b1;
                    CMD_OFS_GET: begin
                        tmr_q <= TMR_W'(EXEC_CYCLES);
                        if (!per_q) begin
                            res_q[0] <= ofs_q;
                            rdok_q <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            if (par_ev) begin
                tmr_q <= TMR_W'(EXEC_CYCLES);
                if (crc_ok) begin
                    case (pcmd_w)
                        CMD_OFS_SET: begin
                            if (!per_q) begin
                                ofs_q <= pword_w;
                            end
                        end
                        CMD_PRS_SET: prs_q <= pword_w;
                        default: ;
                    endcase
                end
            end
        end
    end

    // Offset steers only T and RH compensation in the core
    assign temp_offset_o = ofs_q;
    assign pressure_o = prs_q;
    assign periodic_o = per_q;
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence addr_done_s;
        st_q == ST_ADDR && scl_fall && cnt_q == 4'h8;
    endsequence
    sequence fetch_ok_s;
        cmd_ev && cmd_w == CMD_FETCH && ff_cnt >= 5'(WORDS_MEAS);
    endsequence

    busy_nack_a: assert property (addr_done_s and busy |=> !oe_q)
        else $error("address acked while busy");
    empty_nack_a: assert property (addr_done_s and sh_q[0] && !rdok_q |=> !oe_q)
        else $error("read acked without data");
    fetch_pop_a: assert property (fetch_ok_s |=> ##3 pop_q == 2'h0)
        else $error("fetch did not pop three words");
    fetch_time_a: assert property (fetch_ok_s |=> tmr_q == TMR_W'(EXEC_CYCLES))
        else $error("fetch execution time wrong");
    stop_hold_a: assert property (cmd_ev && cmd_w == CMD_STOP |=>
        !per_q && tmr_q == TMR_W'(STOP_CYCLES))
        else $error("stop did not idle and hold off");
    idle_get_a: assert property (cmd_ev && cmd_w == CMD_OFS_GET && per_q
        |=> !rdok_q)
        else $error("offset read served while measuring");
    ofs_guard_a: assert property ($changed(ofs_q) |->
        $past(par_ev && crc_ok && !per_q))
        else $error("offset changed without valid write");
    trunc_rel_a: assert property (st_q == ST_RACK && scl_fall && !mack_q &&
        !bus_start && !bus_stop |=> st_q == ST_IDLE && !oe_q)
        else $error("bus not released after master nack");
endmodule // gsr_cmd_top
`default_nettype wire

// ==== inc/gsr_pkg.sv ====
`default_nettype none
package gsr_pkg;
    // Bus address and command codes
    localparam logic [6:0] DEV_ADDR = 7'h62;
    localparam logic [15:0] CMD_FETCH = 16'hEC05;
    localparam logic [15:0] CMD_STOP = 16'h3F86;
    localparam logic [15:0] CMD_START = 16'h21B1;
    localparam logic [15:0] CMD_OFS_SET = 16'h241D;
    localparam logic [15:0] CMD_OFS_GET = 16'h2318;
    localparam logic [15:0] CMD_PRS_SET = 16'hE000;
    // Settings after power-up; offset word for 4 degC
    localparam logic [15:0] OFS_RST = 16'h05DA;
    localparam logic [15:0] PRS_RST = 16'h0000;
    // Word checksum
    localparam logic [7:0] CRC_POLY = 8'h31;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    // Timing
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned T_EXEC_US = 1000;
    localparam int unsigned T_STOP_MS = 500;
    localparam int unsigned EXEC_CYC = T_EXEC_US * CLK_MHZ;
    localparam int unsigned STOP_CYC = T_STOP_MS * 1000 * CLK_MHZ;
    localparam int unsigned TMR_W = 27;
    // Result buffer
    localparam int unsigned FIFO_W = 16;
    localparam int unsigned FIFO_D = 16;
    localparam int unsigned WORDS_MEAS = 3;
    localparam int unsigned BYTES_CMD = 2;
    localparam int unsigned BYTES_PAR = 5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h3,
        ST_WRB = 3'h2,
        ST_WACK = 3'h6,
        ST_RDB = 3'h7,
        ST_RACK = 3'h5
    } gsr_bus_st_type;
endpackage
`default_nettype wire

// ==== dv/gsr_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module gsr_master (
    // Clock
    input wire logic clk_i,
    // Bus pins
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic low_q = 1'b0;

    initial scl_o = 1'b1;

    // Pull-up: a released line reads high, never the last value
    assign sda_o = ~(low_q | sda_oe_i);

    // Both clock phases at least 5 cycles, well above the 2-cycle delay of the synchroniser
    task automatic hc();
        repeat (5) @(posedge clk_i);
        #1;
    endtask

    task automatic xfer(input logic b, output logic r);
        hc();
        low_q = ~b;
        hc();
        scl_o = 1'b1;
        hc();
        r = sda_o;
        scl_o = 1'b0;
    endtask

    task automatic start();
        hc();
        low_q = 1'b1;
        hc();
        scl_o = 1'b0;
    endtask

    task automatic stop();
        hc();
        low_q = 1'b1;
        hc();
        scl_o = 1'b1;
        hc();
        low_q = 1'b0;
        hc();
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(b[i], r);
        xfer(1'b1, r);
        ack = ~r;
    endtask

    // Last byte is answered with NACK, which ends the read
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, r);
            b[i] = r;
        end
        xfer(last, r);
    endtask
endmodule // gsr_master
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench import gsr_pkg::*;;
    // Shortened execution and stop windows
    localparam int unsigned EXEC = 600;
    localparam int unsigned STOPC = 1500;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic scl, sda, sda_oe, mr, per, sdo;
    logic mv = 1'b0;
    logic [15:0] md = 16'h0000;
    logic [15:0] ofs, prs;
    logic [7:0] q [$];
    int n_fail = 0;
    int n_compared = 0;

    always #2.5 clk_i = ~clk_i;

    gsr_cmd_top #(.EXEC_CYCLES(EXEC), .STOP_CYCLES(STOPC)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sdo), .sda_oe_o(sda_oe), .meas_valid_i(mv),
        .meas_data_i(md), .meas_ready_o(mr), .periodic_o(per),
        .temp_offset_o(ofs), .pressure_o(prs)
    );

    gsr_master m (
        .clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda)
    );

    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
            c = (c[7] ^ w[i]) ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        return c;
    endfunction

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        n_compared++;
        if (got !== exp) begin
            $display("MISMATCH %0t %s", $time, msg);
            n_fail++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Core offers n consecutive words, valid held across the run
    task automatic push(input logic [15:0] base, input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            mv = 1'b1;
            md = base + 16'(i);
            k = 0;
            while (mr !== 1'b1 && k < 100) begin
                cyc(1);
                k++;
            end
            cyc(1);
        end
        mv = 1'b0;
    endtask

    task automatic send(input logic [15:0] c, input logic par,
                        input logic [15:0] w, input logic [7:0] k);
        logic a;
        logic [7:0] b [6];
        b = '{{DEV_ADDR, 1'b0}, c[15:8], c[7:0], w[15:8], w[7:0], k};
        m.start();
        for (int i = 0; i < (par ? 6 : 3); i++) begin
            m.wbyte(b[i], a);
            chk(a, 1'b1, "write byte not acknowledged");
        end
        m.stop();
    endtask

    task automatic rd(input int n, input logic ok);
        logic a;
        logic [7:0] b;
        q.delete();
        m.start();
        m.wbyte({DEV_ADDR, 1'b1}, a);
        chk(a, ok, "read header answer");
        if (a) begin
            for (int i = 0; i < n; i++) begin
                m.rbyte(i == n - 1, b);
                q.push_back(b);
            end
        end
        m.stop();
        chk(sda_oe, 1'b0, "bus not released");
    endtask

    task automatic expw(input int i, input logic [15:0] w);
        chk({q[i], q[i + 1]}, w, "word value");
        chk(q[i + 2], crc8(w), "word checksum");
    endtask

    task automatic fetch(input logic [15:0] w, input logic ok);
        send(CMD_FETCH, 1'b0, 16'h0000, 8'h00);
        cyc(EXEC);
        rd(9, ok);
        if (ok) begin
            for (int i = 0; i < 3; i++) expw(3 * i, w + 16'(i));
        end
    endtask

    task automatic t_reset();
        chk(ofs, OFS_RST, "offset after reset");
        chk(prs, PRS_RST, "pressure after reset");
        chk(per, 1'b0, "mode after reset");
        chk(sda_oe, 1'b0, "data line after reset");
        chk(sdo, 1'b0, "open drain level not low");
        chk(mr, 1'b1, "buffer ready after reset");
    endtask

    task automatic t_fetch();
        fetch(16'h0000, 1'b0);
        push(16'h6000, 3);
        fetch(16'h6000, 1'b1);
        fetch(16'h6000, 1'b0);
        push(16'h7000, 3);
        send(CMD_FETCH, 1'b0, 16'h0000, 8'h00);
        cyc(EXEC);
        rd(2, 1'b1);
        chk({q[0], q[1]}, 16'h7000, "truncated word");
        fetch(16'h0000, 1'b0);
    endtask

    task automatic t_offset();
        send(CMD_OFS_GET, 1'b0, 16'h0000, 8'h00);
        rd(3, 1'b0);
        cyc(EXEC);
        rd(3, 1'b1);
        expw(0, OFS_RST);
        send(CMD_OFS_SET, 1'b1, 16'h07E6, 8'h48);
        cyc(EXEC);
        chk(ofs, 16'h07E6, "offset written");
        send(CMD_OFS_SET, 1'b1, 16'h0912, 8'h00);
        cyc(EXEC);
        chk(ofs, 16'h07E6, "bad checksum accepted");
    endtask

    task automatic t_mode();
        logic a;
        send(CMD_START, 1'b0, 16'h0000, 8'h00);
        chk(per, 1'b1, "periodic mode");
        send(CMD_OFS_SET, 1'b1, 16'h0100, crc8(16'h0100));
        cyc(EXEC);
        chk(ofs, 16'h07E6, "offset set while periodic");
        send(CMD_OFS_GET, 1'b0, 16'h0000, 8'h00);
        cyc(EXEC);
        rd(3, 1'b0);
        send(CMD_PRS_SET, 1'b1, 16'h03DB, 8'h42);
        cyc(EXEC);
        chk(prs, 16'h03DB, "pressure written");
        send(CMD_STOP, 1'b0, 16'h0000, 8'h00);
        chk(per, 1'b0, "idle after stop");
        rd(3, 1'b0);
        // A pending-free read is refused anyway, so also try a write
        m.start();
        m.wbyte({DEV_ADDR, 1'b0}, a);
        m.stop();
        chk(a, 1'b0, "command taken in stop hold");
        cyc(STOPC);
        send(CMD_OFS_GET, 1'b0, 16'h0000, 8'h00);
        cyc(EXEC);
        rd(3, 1'b1);
        expw(0, 16'h07E6);
    endtask

    // Fill to refusal, then drain; offset is non-default here
    task automatic t_fill();
        push(16'h1000, 16);
        chk(mr, 1'b0, "buffer full not refused");
        for (int i = 0; i < 5; i++) fetch(16'h1000 + 16'(3 * i), 1'b1);
        chk(mr, 1'b1, "buffer ready after drain");
        fetch(16'h0000, 1'b0);
        push(16'h1010, 2);
        fetch(16'h100F, 1'b1);
        fetch(16'h0000, 1'b0);
    endtask

    initial begin
        repeat (80000) @(posedge clk_i);
        n_fail++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        cyc(3);
        t_reset();
        t_fetch();
        t_offset();
        t_mode();
        t_fill();
        end_sim();
    end
endmodule // testbench
`default_nettype wire
